// ### src/np_access_top.sv
// Top: register port, hold-off logic and crossing to the PCI-clock side
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] Four 32-bit registers drive configuration cycles
// [R2] Memory and I/O cycles, single phase only
// [R3] Read starts after command register write
// [R4] Read data stored in read register
// [R5] Reads retried until read data stored
// [R6] Write starts on write-data register write
// [R7] Writes retried until write completes
// [R8] Stored values driven onto bus unchanged; memory reads drive all byte enables on, not the stored ones
// [R9] Software aligns I/O enables with address
// [R10] Memory reads always full word
// [R11] Memory reads assert all byte enables
// [R12] Narrow targets abort full-width reads
// [R13] Software uses I/O reads for subwords
// [R14] Device field picks one of 32
// [R15] Bus field picks one of 256
// [R16] Address bits 1:0 give cycle type
// [R17] Command register: enables 7:4, command 3:0
// [R18] Config write 1011b, read 1010b
// [R19] Bus-master enable set before config cycles
// [R20] Type 1 field layout in address
module np_access_top
  import np_access_pkg::*;
(
  // Register clock and reset
  input  wire logic        CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic        REG_SEL,
  input  wire logic        REG_WRITE,
  input  wire logic [3:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  output var  logic [31:0] REG_RDATA,
  output var  logic        REG_READY,
  output var  logic        REG_RETRY,
  // Link clock and reset
  input  wire logic        PCI_CLK,
  input  wire logic        PCI_RST,
  // PCI single-transfer port
  output var  logic        PCI_START,
  output var  logic [31:0] PCI_ADDR,
  output var  logic [3:0]  PCI_CMD,
  output var  logic [3:0]  PCI_BE_N,
  output var  logic [31:0] PCI_WDATA,
  input  wire logic        PCI_DONE,
  input  wire logic        PCI_ABORT,
  input  wire logic [31:0] PCI_RDATA,
  // Type 1 decode of the stored address
  output var  logic [7:0]  CFG_BUS,
  output var  logic [4:0]  CFG_DEV,
  output var  logic [2:0]  CFG_FUNC
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    host_st_t    st;
    logic [31:0] addr;
    logic [31:0] cbe;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        abort;
    logic        is_read;
    logic        req_tgl;
    logic        ack_seen;
    logic [31:0] rd_out;
    logic        rd_valid;
  } host_state_t;

  host_state_t cur_q;
  host_state_t cur_d;
  np_req_t     req;
  np_rsp_t     rsp;
  np_req_t     pci_req;
  logic        ack_tgl;
  logic        ack_sync;
  logic        busy;
  logic        rd_hit;
  logic        wr_hit;

  // ****************************************************************
  // Crossing
  // ****************************************************************
  np_sync_bit u_ack_sync (
    .clk (CLK),
    .rst (RST),
    .d   (ack_tgl),
    .q   (ack_sync)
  );

  np_link_side u_link (
    .pci_clk   (PCI_CLK),
    .pci_rst   (PCI_RST),
    .req       (req),
    .req_tgl   (cur_q.req_tgl),
    .ack_tgl   (ack_tgl),
    .rsp       (rsp),
    .pci_start (PCI_START),
    .pci_req   (pci_req),
    .pci_done  (PCI_DONE),
    .pci_abort (PCI_ABORT),
    .pci_rdata (PCI_RDATA)
  );

  always_comb begin
    req.addr    = cur_q.addr; // [R8]
    req.cmd     = cur_q.cbe[CBE_CMD_LSB +: 4];
    req.be_n    = cur_q.cbe[CBE_BE_LSB +: 4];
    req.wdata   = cur_q.wdata;
    req.is_read = cur_q.is_read;
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  assign busy      = (cur_q.st != ST_IDLE);
  assign rd_hit    = REG_SEL && !REG_WRITE;
  assign wr_hit    = REG_SEL && REG_WRITE;
  assign REG_RETRY = REG_SEL && busy; // [R5] [R7]
  assign REG_READY = REG_SEL && !busy;

  always_comb begin
    cur_d          = cur_q;
    cur_d.rd_valid = 1'b0;
    unique case (cur_q.st)
      ST_IDLE: begin
        if (wr_hit) begin
          unique case (REG_ADDR)
            OFF_ADDRESS: cur_d.addr = REG_WDATA; // [R1]
            OFF_CBE: begin
              cur_d.cbe = REG_WDATA;
              if (!REG_WDATA[CBE_CMD_LSB]) begin
                cur_d.is_read = 1'b1; // [R3]
                cur_d.req_tgl = ~cur_q.req_tgl;
                cur_d.st      = ST_BUSY;
              end
            end
            OFF_WDATA: begin
              cur_d.wdata   = REG_WDATA;
              cur_d.is_read = 1'b0; // [R6]
              cur_d.req_tgl = ~cur_q.req_tgl;
              cur_d.st      = ST_BUSY;
            end
            default: ;
          endcase
        end else if (rd_hit) begin
          cur_d.rd_valid = 1'b1;
          unique case (REG_ADDR)
            OFF_ADDRESS: cur_d.rd_out = cur_q.addr;
            OFF_CBE:     cur_d.rd_out = cur_q.cbe;
            OFF_WDATA:   cur_d.rd_out = cur_q.wdata;
            OFF_RDATA:   cur_d.rd_out = cur_q.rdata;
            OFF_STATUS:  cur_d.rd_out = {31'h0000_0000, cur_q.abort};
            default:     cur_d.rd_out = RST_REG;
          endcase
        end
      end
      ST_BUSY: begin
        if (ack_sync != cur_q.ack_seen) begin
          cur_d.ack_seen = ack_sync;
          cur_d.st       = ST_DONE;
        end
      end
      ST_DONE: begin
        if (cur_q.is_read) begin
          cur_d.rdata = rsp.rdata; // [R4]
        end
        cur_d.abort = rsp.abort;
        cur_d.st    = ST_IDLE;
      end
      default: cur_d.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign REG_RDATA = cur_q.rd_out;
  assign PCI_ADDR  = pci_req.addr;
  assign PCI_CMD   = pci_req.cmd;
  assign PCI_BE_N  = pci_req.be_n;
  assign PCI_WDATA = pci_req.wdata;
  assign CFG_BUS   = cur_q.addr[CFG_BUS_LSB +: 8]; // [R15]
  assign CFG_DEV   = cur_q.addr[CFG_DEV_LSB +: 5]; // [R14]
  assign CFG_FUNC  = cur_q.addr[CFG_FUNC_LSB +: 3];

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_rd_launch;
    wr_hit && !busy && (REG_ADDR == OFF_CBE) && !REG_WDATA[0];
  endsequence

  sequence s_wr_launch;
    wr_hit && !busy && (REG_ADDR == OFF_WDATA);
  endsequence

  sequence s_refused_wr;
    wr_hit && busy;
  endsequence

  sequence s_ack_arrive;
    (cur_q.st == ST_BUSY) && (ack_sync != cur_q.ack_seen);
  endsequence

  chk_rd_goes_busy: assert property (@(posedge CLK) disable iff (RST) // [R3]
    s_rd_launch |=> busy && cur_q.is_read)
    else $error("read launch did not go busy");

  chk_wr_goes_busy: assert property (@(posedge CLK) disable iff (RST) // [R6]
    (wr_hit && !busy && REG_ADDR == OFF_WDATA) |=> busy && !cur_q.is_read)
    else $error("write launch did not go busy");

  chk_retry_busy: assert property (@(posedge CLK) disable iff (RST) // [R5]
    (REG_SEL && busy) |-> REG_RETRY && !REG_READY)
    else $error("access not retried while busy");

  chk_no_store_busy: assert property (@(posedge CLK) disable iff (RST) // [R7]
    s_refused_wr |=> $stable(cur_q.wdata))
    else $error("write data changed while busy");

  chk_rdata_store: assert property (@(posedge CLK) disable iff (RST) // [R4]
    (cur_q.st == ST_DONE && cur_q.is_read) |=> cur_q.rdata == $past(rsp.rdata))
    else $error("read data not stored");

  chk_addr_pass: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R8]
    PCI_START |-> PCI_ADDR == cur_q.addr && PCI_CMD == cur_q.cbe[3:0]
      && PCI_WDATA == cur_q.wdata)
    else $error("address altered on bus");

  chk_mem_be_all: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R11]
    (PCI_START && PCI_CMD == CMD_MEM_READ) |-> PCI_BE_N == BE_ALL_ON_N)
    else $error("memory read without all enables");

  chk_single_start: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R2]
    $fell(PCI_START) |=> !PCI_START)
    else $error("start not followed by a gap");

  chk_cfg_fields: assert property (@(posedge CLK) disable iff (RST) // [R14] [R15]
    (wr_hit && !busy && REG_ADDR == OFF_ADDRESS) |=> CFG_DEV == $past(REG_WDATA[15:11])
      && CFG_BUS == $past(REG_WDATA[23:16]) && CFG_FUNC == $past(REG_WDATA[10:8]))
    else $error("type 1 fields misplaced");

  // ****************************************************************
  // Hold-off and link checks
  // ****************************************************************
  chk_ready_idle: assert property (@(posedge CLK) disable iff (RST) // [R1]
    (REG_SEL && !busy) |-> REG_READY && !REG_RETRY)
    else $error("idle access not taken");

  chk_rdata_stands: assert property (@(posedge CLK) disable iff (RST) // [R4]
    !cur_q.rd_valid |-> $stable(REG_RDATA))
    else $error("read data changed without a read");

  chk_rd_reg_out: assert property (@(posedge CLK) disable iff (RST) // [R4]
    (rd_hit && !busy && REG_ADDR == OFF_RDATA) |=> REG_RDATA == cur_q.rdata)
    else $error("read data register not returned");

  chk_refused_regs: assert property (@(posedge CLK) disable iff (RST) // [R7]
    s_refused_wr |=> $stable(cur_q.addr) && $stable(cur_q.cbe))
    else $error("refused write changed a register");

  chk_busy_waits: assert property (@(posedge CLK) disable iff (RST) // [R5]
    (cur_q.st == ST_BUSY && ack_sync == cur_q.ack_seen) |=> cur_q.st == ST_BUSY)
    else $error("left busy before completion");

  chk_ack_done: assert property (@(posedge CLK) disable iff (RST) // [R5]
    s_ack_arrive |=> cur_q.st == ST_DONE)
    else $error("completion not taken");

  chk_done_idle: assert property (@(posedge CLK) disable iff (RST) // [R4]
    (cur_q.st == ST_DONE) |=> cur_q.st == ST_IDLE && cur_q.abort == $past(rsp.abort))
    else $error("abort status not stored");

  chk_cbe_no_launch: assert property (@(posedge CLK) disable iff (RST) // [R6]
    (wr_hit && !busy && REG_ADDR == OFF_CBE && REG_WDATA[0]) |=> !busy)
    else $error("write command launched early");

  chk_wr_toggle: assert property (@(posedge CLK) disable iff (RST) // [R6]
    s_wr_launch |=> cur_q.req_tgl != $past(cur_q.req_tgl))
    else $error("write launch not signalled");

  chk_start_busy: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R2]
    $rose(PCI_START) |-> busy)
    else $error("transfer without a request");

  chk_be_pass: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R8]
    (PCI_START && PCI_CMD != CMD_MEM_READ) |-> PCI_BE_N == cur_q.cbe[7:4])
    else $error("byte enables altered on bus");

  chk_fields_hold: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R8]
    (PCI_START && $past(PCI_START)) |-> $stable(PCI_ADDR) && $stable(PCI_WDATA))
    else $error("bus fields changed during transfer");

  chk_mem_full_word: assert property (@(posedge PCI_CLK) disable iff (PCI_RST) // [R10]
    (PCI_START && PCI_CMD == CMD_MEM_READ) |-> cur_q.is_read && PCI_ADDR == cur_q.addr)
    else $error("memory read not a full word read");

endmodule // np_access_top

`default_nettype wire

// ### src/np_access_pkg.sv
// Package: register map, PCI commands, carriers and states for the single-access initiator
package np_access_pkg;

  // ****************************************************************
  // Register map (word offsets on the internal register port)
  // ****************************************************************
  localparam logic [3:0] OFF_ADDRESS = 4'h0;
  localparam logic [3:0] OFF_CBE     = 4'h4;
  localparam logic [3:0] OFF_WDATA   = 4'h8;
  localparam logic [3:0] OFF_RDATA   = 4'hC;
  localparam logic [3:0] OFF_STATUS  = 4'h1;

  localparam logic [31:0] RST_REG = 32'h0000_0000;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CBE_CMD_LSB = 0;
  localparam int CBE_BE_LSB  = 4;
  localparam int CFG_TYPE_LSB = 0;
  localparam int CFG_REG_LSB  = 2;
  localparam int CFG_FUNC_LSB = 8;
  localparam int CFG_DEV_LSB  = 11;
  localparam int CFG_BUS_LSB  = 16;

  // ****************************************************************
  // PCI commands
  // ****************************************************************
  localparam logic [3:0] CMD_IO_READ   = 4'h2;
  localparam logic [3:0] CMD_IO_WRITE  = 4'h3;
  localparam logic [3:0] CMD_MEM_READ  = 4'h6;
  localparam logic [3:0] CMD_MEM_WRITE = 4'h7;
  localparam logic [3:0] CMD_CFG_READ  = 4'hA;
  localparam logic [3:0] CMD_CFG_WRITE = 4'hB;
  localparam logic [3:0] BE_ALL_ON_N   = 4'h0;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic [31:0] addr;
    logic [3:0]  cmd;
    logic [3:0]  be_n;
    logic [31:0] wdata;
    logic        is_read;
  } np_req_t;

  typedef struct packed {
    logic [31:0] rdata;
    logic        abort;
  } np_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01,
    ST_DONE = 2'b11
  } host_st_t;

  typedef enum logic [1:0] {
    LK_IDLE = 2'b00,
    LK_RUN  = 2'b01,
    LK_ACK  = 2'b11
  } link_st_t;

endpackage

// ### src/np_sync_bit.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none

module np_sync_bit
  import np_access_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level
  input  wire logic d,
  output var  logic q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_st_t;

  sync_st_t cur_q;
  sync_st_t cur_d;

  always_comb begin
    cur_d    = cur_q;
    cur_d.s1 = d;
    cur_d.s2 = cur_q.s1;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  assign q = cur_q.s2;

endmodule // np_sync_bit

`default_nettype wire

// ### src/np_link_side.sv
// PCI-clock side: runs one single-data-phase cycle per request toggle
`timescale 1ns/1ps
`default_nettype none

module np_link_side
  import np_access_pkg::*;
(
  // Link clock and reset
  input  wire logic    pci_clk,
  input  wire logic    pci_rst,
  // Request from register side, held stable while toggle differs
  input  wire np_req_t req,
  input  wire logic    req_tgl,
  output var  logic    ack_tgl,
  output var  np_rsp_t rsp,
  // PCI single-transfer port
  output var  logic    pci_start,
  output var  np_req_t pci_req,
  input  wire logic    pci_done,
  input  wire logic    pci_abort,
  input  wire logic [31:0] pci_rdata
);

  typedef struct packed {
    link_st_t st;
    logic     ack;
    logic     seen;
    np_req_t  out;
    np_rsp_t  rsp;
    logic     done_s1;
    logic     done_s2;
    logic     abort_s1;
    logic     abort_s2;
    logic [31:0] rd_s1;
    logic [31:0] rd_s2;
  } link_state_t;

  link_state_t cur_q;
  link_state_t cur_d;
  logic        req_seen;

  np_sync_bit u_req_sync (
    .clk (pci_clk),
    .rst (pci_rst),
    .d   (req_tgl),
    .q   (req_seen)
  );

  always_comb begin
    cur_d          = cur_q;
    cur_d.done_s1  = pci_done;
    cur_d.done_s2  = cur_q.done_s1;
    cur_d.abort_s1 = pci_abort;
    cur_d.abort_s2 = cur_q.abort_s1;
    cur_d.rd_s1    = pci_rdata;
    cur_d.rd_s2    = cur_q.rd_s1;
    unique case (cur_q.st)
      LK_IDLE: begin
        if (req_seen != cur_q.seen) begin
          cur_d.seen = req_seen;
          cur_d.out  = req; // [R8]
          if (req.is_read && (req.cmd == CMD_MEM_READ)) begin
            cur_d.out.be_n = BE_ALL_ON_N; // [R10] [R11]
          end
          cur_d.st = LK_RUN; // [R2]
        end
      end
      LK_RUN: begin
        if (cur_q.done_s2) begin
          cur_d.rsp.rdata = cur_q.rd_s2;
          cur_d.rsp.abort = cur_q.abort_s2;
          cur_d.st        = LK_ACK;
        end
      end
      LK_ACK: begin
        cur_d.ack = ~cur_q.ack;
        cur_d.st  = LK_IDLE;
      end
      default: cur_d.st = LK_IDLE;
    endcase
  end

  always_ff @(posedge pci_clk or posedge pci_rst) begin
    if (pci_rst) begin
      cur_q <= '0;
    end else begin
      cur_q <= cur_d;
    end
  end

  assign ack_tgl   = cur_q.ack;
  assign rsp       = cur_q.rsp;
  assign pci_start = (cur_q.st == LK_RUN);
  assign pci_req   = cur_q.out;

endmodule // np_link_side

`default_nettype wire

// ### test/np_target_model.sv
// Behavioural PCI target answering one single-phase transfer at a time
`timescale 1ns/1ps
`default_nettype none

module np_target_model (
  // Link clock and reset
  input  wire logic        pci_clk,
  input  wire logic        pci_rst,
  // Transfer request and scenario controls
  input  wire logic        start,
  input  wire logic [3:0]  wait_cyc,
  input  wire logic        abort_req,
  input  wire logic [31:0] data_in,
  // Completion
  output var  logic        done,
  output var  logic        abort,
  output var  logic [31:0] rdata
);
  // ****************************************
  // Answer after wait_cyc cycles, hold until start drops
  // ****************************************
  logic [3:0] cnt_q;

  always_ff @(posedge pci_clk or posedge pci_rst) begin
    if (pci_rst) begin
      cnt_q <= 4'h0;
      done  <= 1'b0;
      abort <= 1'b0;
      rdata <= 32'h5A5A_A5A5;
    end else if (start && !done) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q >= wait_cyc) begin
        done  <= 1'b1;
        abort <= abort_req;
        rdata <= data_in;
      end
    end else if (!start) begin
      cnt_q <= 4'h0;
      done  <= 1'b0;
      abort <= 1'b0;
      rdata <= ~rdata;
    end
  end
endmodule // np_target_model

`default_nettype wire

// ### test/tb.sv
// Self-checking testbench for the single-access initiator
`timescale 1ns/1ps
`default_nettype none

module tb
  import np_access_pkg::*;
;
  // ****************************************
  // Signals
  // ****************************************
  logic        CLK, RST, PCI_CLK, PCI_RST, REG_SEL, REG_WRITE;
  logic        REG_READY, REG_RETRY, PCI_START, PCI_DONE, PCI_ABORT;
  logic [3:0]  REG_ADDR, PCI_CMD, PCI_BE_N, wait_cyc;
  logic [31:0] REG_WDATA, REG_RDATA, PCI_ADDR, PCI_WDATA, PCI_RDATA;
  logic [7:0]  CFG_BUS;
  logic [4:0]  CFG_DEV;
  logic [2:0]  CFG_FUNC;
  logic        abort_req, start_q, rt;
  logic [31:0] data_in, q, a;
  logic [3:0]  be;
  int          n_errors, n_checks, seed, cycles;
  np_req_t     exp_q[$];
  np_req_t     e;
  logic [3:0]  cmds [6] = '{CMD_IO_READ, CMD_IO_WRITE, CMD_MEM_READ,
                            CMD_MEM_WRITE, CMD_CFG_READ, CMD_CFG_WRITE};

  np_access_top i_dut (.CLK(CLK), .RST(RST), .REG_SEL(REG_SEL),
    .REG_WRITE(REG_WRITE), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_RDATA(REG_RDATA), .REG_READY(REG_READY), .REG_RETRY(REG_RETRY),
    .PCI_CLK(PCI_CLK), .PCI_RST(PCI_RST), .PCI_START(PCI_START),
    .PCI_ADDR(PCI_ADDR), .PCI_CMD(PCI_CMD), .PCI_BE_N(PCI_BE_N),
    .PCI_WDATA(PCI_WDATA), .PCI_DONE(PCI_DONE), .PCI_ABORT(PCI_ABORT),
    .PCI_RDATA(PCI_RDATA), .CFG_BUS(CFG_BUS), .CFG_DEV(CFG_DEV),
    .CFG_FUNC(CFG_FUNC));

  np_target_model i_tgt (.pci_clk(PCI_CLK), .pci_rst(PCI_RST),
    .start(PCI_START), .wait_cyc(wait_cyc), .abort_req(abort_req),
    .data_in(data_in), .done(PCI_DONE), .abort(PCI_ABORT),
    .rdata(PCI_RDATA));

  // ****************************************
  // Clocks, timeout and transfer watcher
  // ****************************************
  always #20 CLK = ~CLK;

  initial begin
    PCI_CLK = 1'b0;
    #13;
    forever #80 PCI_CLK = ~PCI_CLK;
  end

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  always @(negedge PCI_CLK) begin
    start_q <= PCI_START;
    if (PCI_START && !start_q) begin
      if (exp_q.size() == 0) begin
        chk(32'h1, 32'h0);
      end else begin
        e = exp_q.pop_front();
        chk(PCI_ADDR, e.addr);
        chk({28'h0, PCI_CMD}, {28'h0, e.cmd});
        chk({28'h0, PCI_BE_N}, {28'h0, e.be_n});
        if (!e.is_read) chk(PCI_WDATA, e.wdata);
      end
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    n_checks++;
    if (seen !== expv) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask

  task automatic acc(input logic w, input logic [3:0] ad, input logic [31:0] d,
                     output logic [31:0] rq, output logic rr);
    @(negedge CLK);
    REG_SEL   = 1'b1;
    REG_WRITE = w;
    REG_ADDR  = ad;
    REG_WDATA = d;
    @(posedge CLK);
    rr = REG_RETRY;
    chk({31'h0, REG_READY}, {31'h0, ~rr});
    @(negedge CLK);
    REG_SEL = 1'b0;
    rq = REG_RDATA;
  endtask

  task automatic run(input logic [3:0] c, input logic [31:0] ad,
                     input logic [3:0] b, input logic ab);
    logic [31:0] d;
    logic [31:0] r;
    logic [31:0] rq;
    logic        rr;
    np_req_t     x;
    int          i;
    d = $random(seed);
    r = $random(seed);
    data_in = r;
    abort_req = ab;
    x.addr = ad;
    x.cmd = c;
    x.be_n = (c == CMD_MEM_READ) ? BE_ALL_ON_N : b;
    x.wdata = d;
    x.is_read = ~c[0];
    acc(1'b1, OFF_ADDRESS, ad, rq, rr);
    if (!c[0]) exp_q.push_back(x);
    acc(1'b1, OFF_CBE, {24'h0, b, c}, rq, rr);
    if (c[0]) begin
      exp_q.push_back(x);
      acc(1'b1, OFF_WDATA, d, rq, rr);
    end
    acc(1'b1, OFF_ADDRESS, ~ad, rq, rr);
    chk({31'h0, rr}, 32'h1);
    acc(1'b0, OFF_RDATA, 32'h0, rq, rr);
    chk({31'h0, rr}, 32'h1);
    chk({16'h0, CFG_BUS, CFG_DEV, CFG_FUNC}, {16'h0, ad[23:8]});
    rr = 1'b1;
    for (i = 0; i < 400 && rr; i++) acc(1'b0, OFF_RDATA, 32'h0, rq, rr);
    chk({31'h0, rr}, 32'h0);
    if (!c[0] && !ab) chk(rq, r);
    if (ab) begin
      acc(1'b0, OFF_STATUS, 32'h0, rq, rr);
      chk({31'h0, rq[0]}, 32'h1);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    seed = 78;
    n_errors = 0;
    n_checks = 0;
    cycles = 0;
    CLK = 1'b0;
    RST = 1'b1;
    PCI_RST = 1'b1;
    REG_SEL = 1'b0;
    REG_WRITE = 1'b0;
    REG_ADDR = 4'h0;
    REG_WDATA = 32'h0;
    wait_cyc = 4'h0;
    abort_req = 1'b0;
    data_in = 32'h0;
    start_q = 1'b0;
    repeat (16) @(posedge CLK);
    @(negedge CLK);
    RST = 1'b0;
    PCI_RST = 1'b0;
    acc(1'b0, OFF_RDATA, 32'h0, q, rt);
    chk(q, RST_REG);
    chk({31'h0, rt}, 32'h0);
    for (int s = 0; s < 2; s++) begin
      wait_cyc = s ? 4'h6 : 4'h0;
      foreach (cmds[k]) begin
        a = $random(seed);
        be = 4'($random(seed));
        a[1:0] = cmds[k][3] ? 2'b01 : 2'b00;
        if (cmds[k][3:1] == 3'h1) be = 4'h0;
        run(cmds[k], a, be, 1'b0);
      end
    end
    acc(1'b1, 4'h2, 32'hFFFF_FFFF, q, rt);
    acc(1'b0, 4'h2, 32'h0, q, rt);
    chk(q, RST_REG);
    acc(1'b0, OFF_ADDRESS, 32'h0, q, rt);
    chk(q, a);
    run(CMD_MEM_READ, {a[31:2], 2'b00}, 4'hF, 1'b1);
    acc(1'b0, OFF_CBE, 32'h0, q, rt);
    chk(q, {24'h0, 4'hF, CMD_MEM_READ});
    chk(exp_q.size(), 32'h0);
    conclude();
  end
endmodule // tb

`default_nettype wire
